// File: src/dmb_consts.svh
`ifndef DMB_CONSTS_SVH
`define DMB_CONSTS_SVH

// Mailbox word width
`define DMB_DATA_W      32
// Control word fields
`define DMB_CTL_VER_HI  31
`define DMB_CTL_VER_LO  28
`define DMB_CTL_OFULL   1
`define DMB_CTL_IFULL   0
`define DMB_CTL_USED_W  6
// Coprocessor slot and register numbers
`define DMB_CP_SLOT     4'hE
`define DMB_CP_REG_CTL  1'h0
`define DMB_CP_REG_DATA 1'h1
// Scan chain number and layout
`define DMB_CHAIN_NUM   4'h2
`define DMB_CHAIN_LEN   34
`define DMB_CHAIN_ADDR  32
`define DMB_CHAIN_WR    33
// Outbound FIFO depth
`define DMB_FIFO_DEPTH  8
// Synchroniser idle levels, interrupt pins high
`define DMB_PIN_IDLE    11'h060

`endif

// File: src/dmb_pkg.sv
package dmb_pkg;
    // One mailbox data word
    typedef logic [31:0] dmb_word_t;
    // Coprocessor register select
    typedef logic [0:0]  dmb_creg_t;
    // Scan chain number as presented by the TAP controller
    typedef logic [3:0]  dmb_chain_t;
endpackage : dmb_pkg

// File: src/dmb_debug_mailbox.sv
`timescale 1ns/100ps
`include "dmb_consts.svh"
// Summary of operation
// - Debug disabled: breakpoint and halt request forced low
// - Debug disabled: acknowledge output forced low
// - Debug disabled: interrupts pass through unchanged
// - Debug disabled: debug logic enters low power
// - 32-bit inbound register, debugger fills, processor reads
// - 32-bit outbound register, processor fills, debugger reads
// - 32-bit control word carries handshake state
// - Control word is read-only
// - Top nibble version code, bits 27:2 reserved
// - Bit 1 flags outbound data awaiting debugger
// - Bit 0 flags inbound data awaiting processor
// - Debugger reaches mailbox over scan chain 2
// - Coprocessor 14: C0 control, C1 data both ways
// - Processor write sets outbound-full flag
// - Debugger read of outbound clears outbound-full
// - Debugger sees synchronised copies of both flags
// - Debugger write of inbound sets inbound-full
// - Processor read of inbound clears inbound-full
// - Receive notify shows inbound word waiting
// - Transmit notify shows outbound register free

// Small first-word-fall-through FIFO with registered ready and valid
module dmb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
    logic [AW-1:0]    wr_ptr_q;        // Write pointer
    logic [AW-1:0]    rd_ptr_q;        // Read pointer
    logic [AW:0]      count_q;         // Words held
    logic [AW:0]      count_d;         // Next word count
    logic             push;            // Accepted write
    logic             pop;             // Accepted read
    logic             ready_q;         // Not full, registered
    logic             valid_q;         // Not empty, registered

    assign push      = in_valid & ready_q;
    assign pop       = out_ready & valid_q;
    assign in_ready  = ready_q;
    assign out_valid = valid_q;
    assign out_data  = mem_q[rd_ptr_q];

    // Occupancy after this cycle's push and pop
    // Push and pop together leave it unchanged
    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // Storage is not reset; only pointers carry meaning
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers, count and registered flags
    // Flags follow the next count, so never late
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            ready_q  <= 1'b1;
            valid_q  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            ready_q <= (count_d != (AW+1)'(DEPTH));
            valid_q <= (count_d != '0);
        end
    end
endmodule : dmb_fifo

// Debug mailbox with debug-disable gating
// Every pin and the link are sampled on mclk
module dmb_debug_mailbox #(
    parameter logic [3:0] VERSION_CODE = 4'h5  // Arbitrary value
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    // Debug gating, pins from outside
    input  wire logic              debug_logic_enable,
    input  wire logic              breakpoint_request_in,
    input  wire logic              debug_halt_request,
    input  wire logic              core_in_debug,
    input  wire logic              normal_interrupt_request_n,
    input  wire logic              fast_interrupt_request_n,
    output logic                   core_breakpoint,
    output logic                   core_debug_request,
    output logic                   debug_acknowledge_out,
    output logic                   core_irq_n,
    output logic                   core_fiq_n,
    // Coprocessor register transfers, same clock
    input  wire logic              cp_req,
    input  wire logic              cp_write,
    input  wire logic [3:0]        cp_slot,
    input  wire dmb_pkg::dmb_creg_t cp_reg,
    input  wire dmb_pkg::dmb_word_t cp_wdata,
    output logic                   cp_wr_ready,
    output dmb_pkg::dmb_word_t     cp_rdata,
    output logic                   cp_rvalid,
    // Scan chain from the TAP controller, asynchronous
    input  wire logic              jtag_tck,
    input  wire logic              jtag_tdi,
    input  wire dmb_pkg::dmb_chain_t scan_chain_sel,
    input  wire logic              scan_capture,
    input  wire logic              scan_shift,
    input  wire logic              scan_update,
    output logic                   jtag_tdo,
    // Notifications, usable as interrupt requests
    output logic                   receive_notify_out,
    output logic                   transmit_notify_out
);
    import dmb_pkg::*;

    localparam int NS = 11;            // Number of synchronised pins
    localparam int CL = `DMB_CHAIN_LEN;

    logic [NS-1:0]   pin_raw;          // Pins gathered for sync
    logic [NS-1:0]   meta_q;           // First stage, read only below
    logic [NS-1:0]   sync_q;           // Second stage, safe to use
    dmb_chain_t      sel_meta_q;       // Chain select, first stage
    dmb_chain_t      sel_sync_q;       // Chain select, retimed
    logic            tck_prev_q;       // Previous synchronised clock
    logic            tck_rise;         // Debugger clock rising edge
    logic            en;               // Synchronised enable
    logic            chain_on;         // Chain 2 selected and enabled
    logic            ofull_q;          // Outbound holds unread data
    logic            ifull_q;          // Inbound holds unread data
    logic [1:0]      ofull_dv_q;       // Debugger-side flag copies
    logic [1:0]      ifull_dv_q;       // Debugger-side flag copies
    dmb_word_t       inbound_q;        // Inbound data register
    dmb_word_t       outbound_q;       // Outbound data register
    logic [CL-1:0]   shift_q;          // Scan shift register
    logic            addr_q;           // Address chosen at update
    logic            wr_q;             // Direction chosen at update
    logic            cap_ev;           // Capture on chain 2
    logic            upd_ev;           // Update on chain 2
    logic            dbg_in_wr;        // Debugger writes inbound
    logic            dbg_out_rd;       // Debugger reads outbound
    logic            cp_ctl_rd;        // Processor reads control
    logic            cp_in_rd;         // Processor reads inbound
    logic            cp_out_wr;        // Processor writes outbound
    logic            fifo_valid;       // Outbound FIFO has a word
    dmb_word_t       fifo_data;        // Outbound FIFO head
    logic            fifo_pop;         // Move head into outbound
    dmb_word_t       ctl_word;         // Control word, processor view
    dmb_word_t       ctl_dbg_word;     // Control word, debugger view

    // Every outside pin goes through two flip-flops
    assign pin_raw = {debug_logic_enable, breakpoint_request_in, debug_halt_request,
                      core_in_debug, normal_interrupt_request_n,
                      fast_interrupt_request_n, jtag_tck, jtag_tdi,
                      scan_capture, scan_shift, scan_update};

    // Stages reset to idle levels: a low interrupt
    // bit would fake a request after every reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta_q     <= `DMB_PIN_IDLE;
            sync_q     <= `DMB_PIN_IDLE;
            tck_prev_q <= 1'b0;
        end else begin
            meta_q     <= pin_raw;
            sync_q     <= meta_q;
            tck_prev_q <= sync_q[4];
        end
    end

    // Chain select is retimed too; its bits may land a
    // cycle apart, harmless as the debugger moves it
    // only between frames, with the link clock still
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sel_meta_q <= '0;
            sel_sync_q <= '0;
        end else begin
            sel_meta_q <= scan_chain_sel;
            sel_sync_q <= sel_meta_q;
        end
    end

    // Chain select is quasi-static while the chain is in use
    assign en       = sync_q[10];
    assign tck_rise = sync_q[4] & ~tck_prev_q;
    assign chain_on = en && (sel_sync_q == `DMB_CHAIN_NUM);
    assign cap_ev   = chain_on & tck_rise & sync_q[2];
    assign upd_ev   = chain_on & tck_rise & sync_q[0];

    // Gating of debug requests and acknowledge; interrupts are only retimed
    // Enable reaches the core three cycles late
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            core_breakpoint       <= 1'b0;
            core_debug_request    <= 1'b0;
            debug_acknowledge_out <= 1'b0;
            core_irq_n            <= 1'b1;
            core_fiq_n            <= 1'b1;
        end else begin
            core_breakpoint       <= en & sync_q[9];
            core_debug_request    <= en & sync_q[8];
            debug_acknowledge_out <= en & sync_q[7];
            // Interrupts never pass through the enable
            // so the debug unit can never mask them
            core_irq_n            <= sync_q[6];
            core_fiq_n            <= sync_q[5];
        end
    end

    // Processor side decode; control writes fall on the floor
    // A write meeting a full queue is lost
    assign cp_ctl_rd = cp_req && !cp_write && cp_slot == `DMB_CP_SLOT
                       && cp_reg == `DMB_CP_REG_CTL;
    assign cp_in_rd  = cp_req && !cp_write && cp_slot == `DMB_CP_SLOT
                       && cp_reg == `DMB_CP_REG_DATA;
    assign cp_out_wr = cp_req && cp_write && cp_slot == `DMB_CP_SLOT
                       && cp_reg == `DMB_CP_REG_DATA;

    // Control word: version nibble, reserved zeros, two flags
    // Reserved bits read zero for forward use
    always_comb begin
        ctl_word = '0;
        ctl_word[`DMB_CTL_VER_HI:`DMB_CTL_VER_LO] = VERSION_CODE;
        ctl_word[`DMB_CTL_OFULL] = ofull_q;
        ctl_word[`DMB_CTL_IFULL] = ifull_q;
        ctl_dbg_word = ctl_word;
        ctl_dbg_word[`DMB_CTL_OFULL] = ofull_dv_q[1];
        ctl_dbg_word[`DMB_CTL_IFULL] = ifull_dv_q[1];
    end

    // Read answers one cycle after the request
    // cp_rdata holds until the next read
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cp_rdata  <= '0;
            cp_rvalid <= 1'b0;
        end else begin
            cp_rvalid <= cp_ctl_rd | cp_in_rd;
            if (cp_ctl_rd) begin
                cp_rdata <= ctl_word;
            end else if (cp_in_rd) begin
                cp_rdata <= inbound_q;
            end
        end
    end

    // Outbound words queue here so software can burst a few
    // Eight words of storage hide debugger latency
    dmb_fifo #(
        .WIDTH (`DMB_DATA_W),
        .DEPTH (`DMB_FIFO_DEPTH)
    ) u_out_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (cp_out_wr),
        .in_ready  (cp_wr_ready),
        .in_data   (cp_wdata),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // Head moves into the outbound register only while it is empty
    // so a write to an idle queue sets the flag a cycle later
    assign fifo_pop = fifo_valid & ~ofull_q;

    // Debugger read of outbound happens at capture of the data address
    // The word is then in the shift register already
    assign dbg_out_rd = cap_ev & addr_q & ~wr_q;
    // Writes into a full inbound register are dropped
    // rather than overwrite an untaken word
    assign dbg_in_wr  = upd_ev & shift_q[`DMB_CHAIN_WR] & shift_q[`DMB_CHAIN_ADDR]
                        & ~ifull_q;

    // Outbound register and its flag; a pop beats a same-cycle clear
    // A read drops only the flag, never the data
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            outbound_q <= '0;
            ofull_q    <= 1'b0;
        end else if (fifo_pop) begin
            outbound_q <= fifo_data;
            ofull_q    <= 1'b1;
        end else if (dbg_out_rd) begin
            ofull_q    <= 1'b0;
        end
    end

    // Inbound register and its flag; a set beats a same-cycle clear
    // Data stays after a read; the flag marks it stale
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            inbound_q <= '0;
            ifull_q   <= 1'b0;
        end else if (dbg_in_wr) begin
            inbound_q <= shift_q[`DMB_DATA_W-1:0];
            ifull_q   <= 1'b1;
        end else if (cp_in_rd) begin
            ifull_q   <= 1'b0;
        end
    end

    // Flag copies retimed for the debugger's view
    // The debugger may see a flag late, never early
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ofull_dv_q <= '0;
            ifull_dv_q <= '0;
        end else begin
            ofull_dv_q <= {ofull_dv_q[0], ofull_q};
            ifull_dv_q <= {ifull_dv_q[0], ifull_q};
        end
    end

    // Scan register; frozen while disabled to save power
    // Capture beats shift, shift beats update
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            shift_q <= '0;
            addr_q  <= 1'b0;
            wr_q    <= 1'b0;
        end else if (cap_ev) begin
            shift_q <= {1'b0, addr_q, addr_q ? outbound_q : ctl_dbg_word};
        end else if (chain_on & tck_rise & sync_q[1]) begin
            shift_q <= {sync_q[3], shift_q[CL-1:1]};
        end else if (upd_ev) begin
            addr_q  <= shift_q[`DMB_CHAIN_ADDR];
            wr_q    <= shift_q[`DMB_CHAIN_WR];
        end
    end

    // Serial out and notifications from flip-flops
    // A deselected chain shows a steady zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            jtag_tdo            <= 1'b0;
            receive_notify_out  <= 1'b0;
            transmit_notify_out <= 1'b1;
        end else begin
            jtag_tdo            <= chain_on & shift_q[0];
            receive_notify_out  <= ifull_q;
            transmit_notify_out <= ~ofull_q;
        end
    end
endmodule : dmb_debug_mailbox

// File: sim/dmb_debug_mailbox_checker.sv
`timescale 1ns/100ps
module dmb_mailbox_checker #(
    parameter logic [3:0] VERSION_CODE = 4'h5
) (
    input wire logic                mclk,
    input wire logic                rstn,
    input wire logic                debug_logic_enable,
    input wire logic                normal_interrupt_request_n,
    input wire logic                fast_interrupt_request_n,
    input wire logic                core_breakpoint,
    input wire logic                core_debug_request,
    input wire logic                debug_acknowledge_out,
    input wire logic                core_irq_n,
    input wire logic                core_fiq_n,
    input wire logic                cp_req,
    input wire logic                cp_write,
    input wire logic [3:0]          cp_slot,
    input wire dmb_pkg::dmb_creg_t  cp_reg,
    input wire logic                cp_wr_ready,
    input wire dmb_pkg::dmb_word_t  cp_rdata,
    input wire logic                cp_rvalid,
    input wire dmb_pkg::dmb_chain_t scan_chain_sel,
    input wire logic                jtag_tdo,
    input wire logic                receive_notify_out,
    input wire logic                transmit_notify_out
);
    import dmb_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic [1:0] irq_pin;  // Interrupt pins, packed
    logic [1:0] irq_out;  // Interrupts towards the core, packed
    logic       rd_q;     // A read was taken at the last edge
    logic       ctl_q;    // The last request addressed the control word
    assign irq_pin = {normal_interrupt_request_n, fast_interrupt_request_n};
    assign irq_out = {core_irq_n, core_fiq_n};
    // Taken reads; reset folded in so no stale answer is expected after release
    always_ff @(posedge mclk) begin
        rd_q <= rstn && cp_req && !cp_write && cp_slot == 4'hE;
    end
    // Register select of the request, for judging the answer one cycle later
    always_ff @(posedge mclk) begin
        ctl_q <= cp_reg == 1'h0;
    end
    // Pin paths run through two sync stages and an output flop, hence five quiet samples
    a_halt_gated_low: assert property (
        !debug_logic_enable [*5] |-> !core_breakpoint && !core_debug_request)
        else $error("halt request leaked");
    a_ack_gated_low: assert property (
        !debug_logic_enable [*5] |-> !debug_acknowledge_out) else $error("ack leaked");
    a_irq_pass_through: assert property (
        $stable(irq_pin) [*5] |-> irq_out == irq_pin) else $error("interrupt altered");
    a_tdo_quiet_off: assert property (
        (!debug_logic_enable || scan_chain_sel != 4'h2) [*5] |-> !jtag_tdo)
        else $error("tdo active while off");
    a_write_sets_full: assert property (
        cp_req && cp_write && cp_slot == 4'hE && cp_reg == 1'h1 && cp_wr_ready
        |-> ##[1:4] !transmit_notify_out) else $error("outbound flag not set");
    a_read_clears_full: assert property (
        cp_req && !cp_write && cp_slot == 4'hE && cp_reg == 1'h1
        |-> ##[1:3] !receive_notify_out) else $error("inbound flag not cleared");
    a_read_answer_once: assert property (
        cp_rvalid == rd_q) else $error("read answer mistimed");
    a_ctl_word_format: assert property (
        cp_rvalid && ctl_q |-> cp_rdata[31:28] == VERSION_CODE && cp_rdata[27:2] == 26'h0)
        else $error("control word malformed");
    a_reset_flags_idle: assert property (
        $rose(rstn) |-> transmit_notify_out && cp_wr_ready && !receive_notify_out)
        else $error("flags not idle after reset");
endmodule : dmb_mailbox_checker

bind dmb_debug_mailbox dmb_mailbox_checker #(.VERSION_CODE(VERSION_CODE)) chk (
    .mclk, .rstn, .debug_logic_enable, .normal_interrupt_request_n,
    .fast_interrupt_request_n, .core_breakpoint, .core_debug_request,
    .debug_acknowledge_out, .core_irq_n, .core_fiq_n, .cp_req, .cp_write, .cp_slot,
    .cp_reg, .cp_wr_ready, .cp_rdata, .cp_rvalid, .scan_chain_sel, .jtag_tdo,
    .receive_notify_out, .transmit_notify_out
);

// File: sim/dmb_host_model.sv
`timescale 1ns/100ps
module dmb_host_model (
    output logic                jtag_tck,
    output logic                jtag_tdi,
    output dmb_pkg::dmb_chain_t scan_chain_sel,
    output logic                scan_capture,
    output logic                scan_shift,
    output logic                scan_update,
    input  wire logic           jtag_tdo
);
    import dmb_pkg::*;
    dmb_chain_t chain = 4'h2;  // Chain in use; the bench may misdirect it
    // Link clock stands low between frames
    initial begin
        {jtag_tck, jtag_tdi, scan_capture, scan_shift, scan_update} = 5'h0;
    end
    assign scan_chain_sel = chain;
    // One 160 ns period; tdo is taken just before the rise, after it has settled
    task automatic tick(input logic c, s, u, d, output logic o);
        {scan_capture, scan_shift, scan_update, jtag_tdi} <= {c, s, u, d};
        #75 o = jtag_tdo;
        #5 jtag_tck <= 1'b1;
        #80 jtag_tck <= 1'b0;
    endtask : tick
    // Optional capture, 34 shifts with the low bit first, then update
    task automatic frame(input logic cap, input logic [33:0] din, output logic [33:0] dout);
        logic o;
        if (cap) tick(1'b1, 1'b0, 1'b0, ~jtag_tdi, o);
        for (int i = 0; i < 34; i++) begin
            tick(1'b0, 1'b1, 1'b0, din[i], dout[i]);
        end
        tick(1'b0, 1'b0, 1'b1, ~din[33], o);
        // Released data line returns to its last shifted level
        {scan_update, jtag_tdi} <= {1'b0, din[33]};
        #160;
    endtask : frame
    // Register access: one frame selects or writes, a second one captures a read
    task automatic access(input logic wr, adr, input dmb_word_t wd, output dmb_word_t rd);
        logic [33:0] o;
        frame(1'b0, {wr, adr, wd}, o);
        if (!wr) frame(1'b1, {wr, adr, wd}, o);
        rd = o[31:0];
    endtask : access
    // Polite deposit: wait, bounded, until the processor has taken the last word
    task automatic put_word(input dmb_word_t wd);
        dmb_word_t c;
        c = 32'h1;
        for (int i = 0; i < 20 && c[0]; i++) access(1'b0, 1'b0, 32'h0, c);
        access(1'b1, 1'b1, wd, c);
    endtask : put_word
endmodule : dmb_host_model

// File: sim/dmb_debug_mailbox_tb.sv
`timescale 1ns/100ps
module dmb_debug_mailbox_tb;
    import dmb_pkg::*;
    localparam logic [3:0] VER = 4'h9;  // Arbitrary version code
    logic mclk = 1'b0, rstn = 1'b0, debug_logic_enable = 1'b1, core_in_debug = 1'b0;
    logic breakpoint_request_in = 1'b0, debug_halt_request = 1'b0;
    logic normal_interrupt_request_n = 1'b1, fast_interrupt_request_n = 1'b1;
    logic core_breakpoint, core_debug_request, debug_acknowledge_out, core_irq_n, core_fiq_n;
    logic cp_req = 1'b0, cp_write = 1'b0, cp_wr_ready, cp_rvalid;
    logic [3:0] cp_slot = 4'hE;
    dmb_creg_t  cp_reg = 1'h0;
    dmb_word_t  cp_wdata = 32'h0, cp_rdata, rd, hd, ib;
    logic jtag_tck, jtag_tdi, scan_capture, scan_shift, scan_update, jtag_tdo;
    dmb_chain_t scan_chain_sel;
    logic receive_notify_out, transmit_notify_out;
    integer seed = 32'h0BBD;
    int errors = 0, tests_run = 0, w_exp = 0, r_exp = 0;  // Counters and model flags
    dmb_word_t ob_q[$];  // Outbound words in flight, oldest first
    dmb_debug_mailbox #(.VERSION_CODE(VER)) dut (
        .mclk, .rstn, .debug_logic_enable, .breakpoint_request_in, .debug_halt_request,
        .core_in_debug, .normal_interrupt_request_n, .fast_interrupt_request_n,
        .core_breakpoint, .core_debug_request, .debug_acknowledge_out, .core_irq_n,
        .core_fiq_n, .cp_req, .cp_write, .cp_slot, .cp_reg, .cp_wdata, .cp_wr_ready,
        .cp_rdata, .cp_rvalid, .jtag_tck, .jtag_tdi, .scan_chain_sel, .scan_capture,
        .scan_shift, .scan_update, .jtag_tdo, .receive_notify_out, .transmit_notify_out
    );
    dmb_host_model host (
        .jtag_tck, .jtag_tdi, .scan_chain_sel, .scan_capture, .scan_shift, .scan_update,
        .jtag_tdo
    );
    initial begin
        forever #10 mclk = ~mclk;
    end
    // Expected control word from the model flags
    function automatic dmb_word_t ctl();
        return {VER, 26'h0, w_exp[0], r_exp[0]};
    endfunction : ctl
    task automatic check(input dmb_word_t got, exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One coprocessor transfer; a read waits, bounded, for its answer
    task automatic cp_op(input logic wr, input dmb_creg_t r, input dmb_word_t d);
        @(posedge mclk);
        {cp_req, cp_write, cp_reg, cp_wdata} <= {1'b1, wr, r, d};
        @(posedge mclk);
        cp_req <= 1'b0;
        #1;
        for (int i = 0; i < 3 && !wr && cp_rvalid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        rd = cp_rdata;
        repeat (4) @(posedge mclk);
    endtask : cp_op
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // Watchdog, far beyond the roughly nine thousand cycles the sequence needs
    initial begin
        repeat (80000) @(posedge mclk);
        errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        check(32'({transmit_notify_out, cp_wr_ready, receive_notify_out}), 32'h6);
        cp_op(1'b0, 1'h0, 32'h0);
        check(rd, ctl());
        cp_op(1'b1, 1'h0, $random(seed));  // Control word ignores writes
        cp_slot <= 4'h3;
        cp_op(1'b1, 1'h1, $random(seed));  // Foreign slot is ignored
        cp_slot <= 4'hE;
        cp_op(1'b0, 1'h0, 32'h0);
        check(rd, ctl());
        $display("test control word done");
        // Fill the outbound register and the queue behind it until refused
        while (cp_wr_ready === 1'b1 && ob_q.size() < 12) begin
            ob_q.push_back($random(seed));
            cp_op(1'b1, 1'h1, ob_q[$]);
            w_exp = 1;
        end
        check(32'(ob_q.size()), 32'h9);
        cp_op(1'b1, 1'h1, 32'hDEAD_BEEF);  // No room: must be dropped
        cp_op(1'b0, 1'h0, 32'h0);
        check(rd, ctl());
        host.access(1'b0, 1'b0, 32'h0, hd);
        check(hd, ctl());
        while (ob_q.size() > 0) begin
            host.access(1'b0, 1'b1, 32'h0, hd);
            check(hd, ob_q.pop_front());
        end
        w_exp = 0;
        cp_op(1'b0, 1'h0, 32'h0);
        check(rd, ctl());
        check(32'(transmit_notify_out), 32'h1);
        ob_q.push_back($random(seed));
        if (rd[1] === 1'b0) cp_op(1'b1, 1'h1, ob_q[0]);
        host.access(1'b0, 1'b1, 32'h0, hd);
        check(hd, ob_q.pop_front());
        $display("test outbound done");
        ib = $random(seed);
        host.put_word(ib);
        r_exp = 1;
        repeat (8) @(posedge mclk);
        check(32'(receive_notify_out), 32'h1);
        host.access(1'b0, 1'b0, 32'h0, hd);
        check(hd, ctl());
        host.access(1'b1, 1'b1, ~ib, hd);  // Deposit while full is dropped
        cp_op(1'b0, 1'h1, 32'h0);
        check(rd, ib);
        r_exp = 0;
        cp_op(1'b0, 1'h0, 32'h0);
        check(rd, ctl());
        $display("test inbound done");
        // Random gating pins; enable low must hide debug but never interrupts
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            {debug_logic_enable, breakpoint_request_in, debug_halt_request, core_in_debug,
                normal_interrupt_request_n, fast_interrupt_request_n} <= 6'($random(seed));
            repeat (6) @(posedge mclk);
            #1;
            check(32'({core_breakpoint, core_debug_request, debug_acknowledge_out}),
                32'({3{debug_logic_enable}} & {breakpoint_request_in, debug_halt_request,
                core_in_debug}));
            check(32'({core_irq_n, core_fiq_n}),
                32'({normal_interrupt_request_n, fast_interrupt_request_n}));
        end
        $display("test gating done");
        // Disabled logic, then a foreign chain: a deposit must leave no trace
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            debug_logic_enable <= k[0];
            host.chain <= k[0] ? 4'h3 : 4'h2;
            host.access(1'b1, 1'b1, $random(seed), hd);
            repeat (8) @(posedge mclk);
            #1;
            check(32'({receive_notify_out, jtag_tdo}), 32'h0);
        end
        $display("test refusals done");
        summarize();
    end
endmodule : dmb_debug_mailbox_tb
